/* File: hdl/core_space_defines.vh */
// Purpose: Shared constants for the address-space configuration and clock-stretch block.
// Assumes: Included by its bare name from every design file except the phase generator.
// Notes:   Definitions only.
`ifndef CORE_SPACE_DEFINES_VH
`define CORE_SPACE_DEFINES_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define REG_MODE_REQ      8'h00
`define REG_CORE_STATUS   8'h04
`define REG_EVENT_STATUS  8'h08
`define REG_EVENT_MASK    8'h0c

// ----------------------------------------------------------------------------
// Event status bit positions
// ----------------------------------------------------------------------------
`define EV_MODE_REFUSED   0
`define EV_EXC_TAKEN      1
`define EV_ADDR_EXC       2
`define EV_CONFIG_BAD     3
`define EV_WIDTH          4

// ----------------------------------------------------------------------------
// Core status fields
// ----------------------------------------------------------------------------
`define ST_MODE_LSB       0
`define ST_PROG_WIDE      8
`define ST_DATA_WIDE      9
`define ST_ADDR_EXC_ON    10

// ----------------------------------------------------------------------------
// Operating modes and reset values
// ----------------------------------------------------------------------------
`define MODE_LEGACY_USER  5'h00
`define MODE_LEGACY_FIQ   5'h01
`define MODE_LEGACY_IRQ   5'h02
`define MODE_LEGACY_SVC   5'h03
`define MODE_WIDE_USER    5'h10
`define MODE_WIDE_FIQ     5'h11
`define MODE_WIDE_IRQ     5'h12
`define MODE_WIDE_SVC     5'h13
`define MODE_RESET        5'h03
`define MASK_RESET        4'h0

// ----------------------------------------------------------------------------
// Exception causes
// ----------------------------------------------------------------------------
`define EXC_ADDR          2'h0
`define EXC_FIQ           2'h1
`define EXC_IRQ           2'h2
`define EXC_TRAP          2'h3

`endif

/* File: hdl/phase_gen.v */
// Purpose: Derives the two main clock phases and the stretched phase-two enable.
// Assumes: One core clock; each core cycle is one phase of the main clock.
// Notes:   A low wait input at the start of a high phase removes the phase-two enable of that phase.
`timescale 1ns/10ps
`default_nettype none

module phase_gen (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire clock_stretch_n_i,
  output reg  phase_high_o,
  output reg  ph2_pulse_o,
  output reg  low_start_o
);

  // --------------------------------------------------------------------------
  // Phase toggle and phase-two enable
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_high_o <= 1'b0;
      ph2_pulse_o  <= 1'b0;
      low_start_o  <= 1'b0;
    end else begin
      phase_high_o <= ~phase_high_o;
      ph2_pulse_o  <= ~phase_high_o & clock_stretch_n_i;
      low_start_o  <= phase_high_o;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/exc_vector.v */
// Purpose: Picks the handler mode for an exception and checks requested modes.
// Assumes: Configuration inputs are the captured strap levels.
// Notes:   Purely combinational.
`timescale 1ns/10ps
`default_nettype none
`include "core_space_defines.vh"

module exc_vector (
  input  wire       prog_wide_i,
  input  wire [1:0] cause_i,
  input  wire [4:0] req_mode_i,
  output reg  [4:0] vector_mode_o,
  output reg        req_legal_o
);

  // --------------------------------------------------------------------------
  // Handler mode and mode legality
  // --------------------------------------------------------------------------
  always @* begin
    case (cause_i)
      `EXC_FIQ: vector_mode_o = prog_wide_i ? `MODE_WIDE_FIQ : `MODE_LEGACY_FIQ;
      `EXC_IRQ: vector_mode_o = prog_wide_i ? `MODE_WIDE_IRQ : `MODE_LEGACY_IRQ;
      default:  vector_mode_o = prog_wide_i ? `MODE_WIDE_SVC : `MODE_LEGACY_SVC;
    endcase
    case (req_mode_i)
      `MODE_LEGACY_USER, `MODE_LEGACY_FIQ,
      `MODE_LEGACY_IRQ, `MODE_LEGACY_SVC: req_legal_o = 1'b1;
      `MODE_WIDE_USER, `MODE_WIDE_FIQ,
      `MODE_WIDE_IRQ, `MODE_WIDE_SVC:     req_legal_o = prog_wide_i;
      default:                            req_legal_o = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

/* File: hdl/core_space_config_wait_stall.v */
// Purpose: Address-space configuration, mode control, exception entry and
//          clock-stretched memory request timing of a 32-bit core.
// Assumes: All inputs synchronous to CORE_CLK_I; one core cycle per clock phase.
// Notes:   Registers on a plain strobe port, read data one cycle after the strobe.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "core_space_defines.vh"

module core_space_config_wait_stall (
  input  wire        CORE_CLK_I,
  input  wire        RST_N_I,
  input  wire        PROGRAM_SPACE_WIDE_SELECT_I,
  input  wire        DATA_SPACE_WIDE_SELECT_I,
  input  wire        CLOCK_STRETCH_N_I,
  input  wire        FAST_INT_N_I,
  input  wire        NORM_INT_N_I,
  input  wire        SOFT_TRAP_I,
  input  wire        COPROC_ABSENT_I,
  input  wire        COPROC_BUSY_I,
  input  wire        DATA_BUS_ENABLE_I,
  input  wire        ACCESS_REQ_I,
  input  wire        ACCESS_DATA_I,
  input  wire        ACCESS_WRITE_I,
  input  wire        ACCESS_BURST_I,
  input  wire [31:0] ACCESS_ADDR_I,
  input  wire [7:0]  REG_ADDR_I,
  input  wire [31:0] REG_WDATA_I,
  input  wire        REG_WRITE_I,
  input  wire        REG_READ_I,
  output reg  [31:0] REG_RDATA_O,
  output reg         IRQ_O,
  output reg         INTERNAL_PHASE_TWO_CLOCK_O,
  output reg         MEMORY_REQUEST_N_O,
  output reg         BURST_CONTINUATION_O,
  output reg  [31:0] ADDRESS_O,
  output reg         DATA_OUTPUT_ENABLE_N_O,
  output reg  [4:0]  MODE_O,
  output reg         ADDR_EXC_ENABLE_O
);

  // --------------------------------------------------------------------------
  // State machine and declarations
  // --------------------------------------------------------------------------
  localparam [1:0] ST_CAPTURE = 2'b01;
  localparam [1:0] ST_RUN     = 2'b10;

  reg  [1:0]             state_reg;
  reg  [1:0]             state_next;
  reg                    prog_wide_reg;
  reg                    data_wide_reg;
  reg                    config_bad_reg;
  reg                    fiq_meta_reg;
  reg                    fiq_sync_reg;
  reg                    irq_meta_reg;
  reg                    irq_sync_reg;
  reg                    trap_pend_reg;
  reg  [4:0]             mode_req_reg;
  reg                    mode_req_pend_reg;
  reg                    cp_absent_reg;
  reg                    cp_busy_reg;
  reg                    clocked_last_reg;
  reg  [`EV_WIDTH-1:0]   ev_status_reg;
  reg  [`EV_WIDTH-1:0]   ev_mask_reg;
  reg  [`EV_WIDTH-1:0]   ev_set;
  reg                    addr_exc;
  reg                    exc_hit;
  reg  [1:0]             exc_cause;
  reg                    busy_wait;
  reg  [31:0]            rd_value;
  wire                   phase_high;
  wire                   ph2_pulse;
  wire                   low_start;
  wire [4:0]             vector_mode;
  wire                   req_legal;
  wire                   running;

  assign running = state_reg[1];

  // --------------------------------------------------------------------------
  // Phase generation
  // --------------------------------------------------------------------------
  phase_gen u_phase (
    .clk_i             (CORE_CLK_I),
    .rst_n_i           (RST_N_I),
    .clock_stretch_n_i (CLOCK_STRETCH_N_I),
    .phase_high_o      (phase_high),
    .ph2_pulse_o       (ph2_pulse),
    .low_start_o       (low_start)
  );

  // --------------------------------------------------------------------------
  // Exception vector and mode check
  // --------------------------------------------------------------------------
  exc_vector u_vector (
    .prog_wide_i   (prog_wide_reg),
    .cause_i       (exc_cause),
    .req_mode_i    (mode_req_reg),
    .vector_mode_o (vector_mode),
    .req_legal_o   (req_legal)
  );

  // --------------------------------------------------------------------------
  // Configuration capture after reset
  // --------------------------------------------------------------------------
  always @* begin
    case (state_reg)
      ST_CAPTURE: state_next = ST_RUN;
      ST_RUN:     state_next = ST_RUN;
      default:    state_next = ST_CAPTURE;
    endcase
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state_reg      <= ST_CAPTURE;
      prog_wide_reg  <= 1'b0;
      data_wide_reg  <= 1'b0;
      config_bad_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_CAPTURE) begin
        // Selects are caught once and held until the next reset.
        prog_wide_reg  <= PROGRAM_SPACE_WIDE_SELECT_I & DATA_SPACE_WIDE_SELECT_I;
        data_wide_reg  <= DATA_SPACE_WIDE_SELECT_I;
        config_bad_reg <= PROGRAM_SPACE_WIDE_SELECT_I & ~DATA_SPACE_WIDE_SELECT_I;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt input synchronisers
  // --------------------------------------------------------------------------
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      fiq_meta_reg <= 1'b0;
      fiq_sync_reg <= 1'b0;
      irq_meta_reg <= 1'b0;
      irq_sync_reg <= 1'b0;
    end else begin
      fiq_meta_reg <= ~FAST_INT_N_I;
      fiq_sync_reg <= fiq_meta_reg;
      irq_meta_reg <= ~NORM_INT_N_I;
      irq_sync_reg <= irq_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Exception selection
  // --------------------------------------------------------------------------
  always @* begin
    // A data access above the 26-bit range faults only with a narrow data space.
    addr_exc  = ACCESS_REQ_I & ACCESS_DATA_I & ~data_wide_reg &
                (ACCESS_ADDR_I[31:26] != 6'h00);
    exc_hit   = 1'b1;
    exc_cause = `EXC_TRAP;
    if (addr_exc) begin
      exc_cause = `EXC_ADDR;
    end else if (fiq_sync_reg) begin
      exc_cause = `EXC_FIQ;
    end else if (irq_sync_reg) begin
      exc_cause = `EXC_IRQ;
    end else if (!trap_pend_reg) begin
      exc_hit = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Mode control, advanced only by the phase-two enable
  // --------------------------------------------------------------------------
  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MODE_O            <= `MODE_RESET;
      mode_req_reg      <= `MODE_RESET;
      mode_req_pend_reg <= 1'b0;
      trap_pend_reg     <= 1'b0;
    end else begin
      if (REG_WRITE_I && REG_ADDR_I == `REG_MODE_REQ) begin
        mode_req_reg      <= REG_WDATA_I[4:0];
        mode_req_pend_reg <= 1'b1;
      end else if (ph2_pulse && running) begin
        mode_req_pend_reg <= 1'b0;
      end
      if (SOFT_TRAP_I) begin
        trap_pend_reg <= 1'b1;
      end else if (ph2_pulse && running && exc_hit && exc_cause == `EXC_TRAP) begin
        trap_pend_reg <= 1'b0;
      end
      if (ph2_pulse && running) begin
        if (exc_hit) begin
          MODE_O <= vector_mode;
        end else if (mode_req_pend_reg && req_legal) begin
          MODE_O <= mode_req_reg;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Memory request sequencing across stretched phases
  // --------------------------------------------------------------------------
  always @* begin
    busy_wait = cp_busy_reg & ~cp_absent_reg;
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      clocked_last_reg           <= 1'b0;
      cp_absent_reg              <= 1'b1;
      cp_busy_reg                <= 1'b0;
      INTERNAL_PHASE_TWO_CLOCK_O <= 1'b0;
      MEMORY_REQUEST_N_O         <= 1'b1;
      BURST_CONTINUATION_O       <= 1'b0;
      ADDRESS_O                  <= 32'h00000000;
      DATA_OUTPUT_ENABLE_N_O     <= 1'b1;
    end else begin
      INTERNAL_PHASE_TWO_CLOCK_O <= ~phase_high & CLOCK_STRETCH_N_I;
      if (phase_high) begin
        clocked_last_reg <= ph2_pulse;
      end
      if (ph2_pulse) begin
        cp_absent_reg <= COPROC_ABSENT_I;
        cp_busy_reg   <= COPROC_BUSY_I;
        if (running) begin
          ADDRESS_O <= ACCESS_ADDR_I;
        end
      end
      if (low_start && clocked_last_reg && running) begin
        MEMORY_REQUEST_N_O   <= ~ACCESS_REQ_I | busy_wait;
        BURST_CONTINUATION_O <= ACCESS_BURST_I & ACCESS_REQ_I & ~busy_wait;
      end
      if (ph2_pulse && running) begin
        DATA_OUTPUT_ENABLE_N_O <= ~(ACCESS_REQ_I & ACCESS_DATA_I & ACCESS_WRITE_I &
                                   DATA_BUS_ENABLE_I & ~busy_wait);
      end else begin
        DATA_OUTPUT_ENABLE_N_O <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Event status, mask and interrupt
  // --------------------------------------------------------------------------
  always @* begin
    ev_set = {`EV_WIDTH{1'b0}};
    ev_set[`EV_MODE_REFUSED] = ph2_pulse & running & ~exc_hit & mode_req_pend_reg & ~req_legal;
    ev_set[`EV_EXC_TAKEN]    = ph2_pulse & running & exc_hit;
    ev_set[`EV_ADDR_EXC]     = ph2_pulse & running & addr_exc;
    ev_set[`EV_CONFIG_BAD]   = config_bad_reg;
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ev_status_reg <= {`EV_WIDTH{1'b0}};
      ev_mask_reg   <= `MASK_RESET;
      IRQ_O         <= 1'b0;
    end else begin
      if (REG_WRITE_I && REG_ADDR_I == `REG_EVENT_STATUS) begin
        // A new event in the clearing cycle survives the clear.
        ev_status_reg <= (ev_status_reg & ~REG_WDATA_I[`EV_WIDTH-1:0]) | ev_set;
      end else begin
        ev_status_reg <= ev_status_reg | ev_set;
      end
      if (REG_WRITE_I && REG_ADDR_I == `REG_EVENT_MASK) begin
        ev_mask_reg <= REG_WDATA_I[`EV_WIDTH-1:0];
      end
      IRQ_O <= |(ev_status_reg & ev_mask_reg);
    end
  end

  // --------------------------------------------------------------------------
  // Register read port
  // --------------------------------------------------------------------------
  always @* begin
    rd_value = 32'h00000000;
    case (REG_ADDR_I)
      `REG_MODE_REQ: begin
        rd_value[4:0] = mode_req_reg;
      end
      `REG_CORE_STATUS: begin
        rd_value[`ST_MODE_LSB+4:`ST_MODE_LSB] = MODE_O;
        rd_value[`ST_PROG_WIDE]               = prog_wide_reg;
        rd_value[`ST_DATA_WIDE]               = data_wide_reg;
        rd_value[`ST_ADDR_EXC_ON]             = ~data_wide_reg;
      end
      `REG_EVENT_STATUS: begin
        rd_value[`EV_WIDTH-1:0] = ev_status_reg;
      end
      `REG_EVENT_MASK: begin
        rd_value[`EV_WIDTH-1:0] = ev_mask_reg;
      end
      default: begin
        rd_value = 32'h00000000;
      end
    endcase
  end

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O       <= 32'h00000000;
      ADDR_EXC_ENABLE_O <= 1'b1;
    end else begin
      REG_RDATA_O       <= REG_READ_I ? rd_value : 32'h00000000;
      ADDR_EXC_ENABLE_O <= ~data_wide_reg;
    end
  end

endmodule

`default_nettype wire

/* File: verif/core_space_chk.sv */
// Purpose: Concurrent checks on the ports of the space configuration and stall block.
// Assumes: One clock domain; phase tracking starts low at reset release.
// Notes:   Attached by bind from the testbench top file.
`timescale 1ns/10ps
`default_nettype none

module core_space_chk (
  input wire logic        CORE_CLK_I,
  input wire logic        RST_N_I,
  input wire logic        PROGRAM_SPACE_WIDE_SELECT_I,
  input wire logic        DATA_SPACE_WIDE_SELECT_I,
  input wire logic        CLOCK_STRETCH_N_I,
  input wire logic        FAST_INT_N_I,
  input wire logic [7:0]  REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic        REG_WRITE_I,
  input wire logic        INTERNAL_PHASE_TWO_CLOCK_O,
  input wire logic        MEMORY_REQUEST_N_O,
  input wire logic        BURST_CONTINUATION_O,
  input wire logic [31:0] ADDRESS_O,
  input wire logic        DATA_OUTPUT_ENABLE_N_O,
  input wire logic [4:0]  MODE_O,
  input wire logic        ADDR_EXC_ENABLE_O
);
  // ---------------------------------------------------------------------------
  // Phase tracking
  // ---------------------------------------------------------------------------
  logic phase_high_reg;

  always @(posedge CORE_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      phase_high_reg <= 1'b0;
    end else begin
      phase_high_reg <= ~phase_high_reg;
    end
  end

  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  chk_wide_req_refused: assert property (
    !PROGRAM_SPACE_WIDE_SELECT_I && !DATA_SPACE_WIDE_SELECT_I && REG_WRITE_I &&
    REG_ADDR_I == 8'h00 && REG_WDATA_I[4] |=> (MODE_O[4] == 1'b0) [*6])
    else $error("wide mode entered in narrow configuration");
  chk_exc_legacy_mode: assert property (
    !PROGRAM_SPACE_WIDE_SELECT_I && $fell(FAST_INT_N_I) |-> ##[1:12] MODE_O == 5'h01)
    else $error("fast interrupt did not enter legacy handler mode");
  chk_addr_exc_off: assert property (
    !PROGRAM_SPACE_WIDE_SELECT_I && DATA_SPACE_WIDE_SELECT_I |-> ##2 !ADDR_EXC_ENABLE_O)
    else $error("address exceptions enabled with wide data space");
  chk_wide_mode_taken: assert property (
    PROGRAM_SPACE_WIDE_SELECT_I && DATA_SPACE_WIDE_SELECT_I && REG_WRITE_I &&
    REG_ADDR_I == 8'h00 && REG_WDATA_I[4:0] == 5'h10 |-> ##[1:6] MODE_O == 5'h10)
    else $error("wide user mode not entered in wide configuration");
  chk_legacy_modes_only: assert property (
    !PROGRAM_SPACE_WIDE_SELECT_I |-> MODE_O[4:2] == 3'b000)
    else $error("non legacy mode with narrow program space");
  chk_stretch_removes_ph2: assert property (
    !phase_high_reg && $past(RST_N_I) |=>
    INTERNAL_PHASE_TWO_CLOCK_O == $past(CLOCK_STRETCH_N_I))
    else $error("phase two output does not follow wait at high phase start");
  chk_stretch_holds_bus: assert property (
    phase_high_reg && !INTERNAL_PHASE_TWO_CLOCK_O |=> $stable(ADDRESS_O) &&
    $stable(MEMORY_REQUEST_N_O) && $stable(BURST_CONTINUATION_O))
    else $error("bus outputs changed after a stretched high phase");
  chk_write_enable_low: assert property (
    !DATA_OUTPUT_ENABLE_N_O |-> !phase_high_reg ##1 DATA_OUTPUT_ENABLE_N_O)
    else $error("data output enable low outside one low phase");
endmodule

`default_nettype wire

/* File: verif/mem_side_model.sv */
// Purpose: Wait-state logic and coprocessor responses of the memory system.
// Assumes: Phase starts low at reset release, as in the core.
// Notes:   Wait changes only at low phase starts so it envelops the next high phase.
`timescale 1ns/10ps
`default_nettype none

module mem_side_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic stall_req_i,
  input  wire logic busy_req_i,
  output var  logic clock_stretch_n_o,
  output var  logic coproc_absent_o,
  output var  logic coproc_busy_o
);
  logic phase_high_reg;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_high_reg    <= 1'b0;
      clock_stretch_n_o <= 1'b1;
      coproc_absent_o   <= 1'b0;
      coproc_busy_o     <= 1'b0;
    end else begin
      phase_high_reg <= ~phase_high_reg;
      if (phase_high_reg) begin
        clock_stretch_n_o <= ~stall_req_i;
      end else begin
        coproc_busy_o <= busy_req_i;
      end
    end
  end
endmodule

`default_nettype wire

/* File: verif/core_space_config_wait_stall_tb.sv */
// Purpose: Self-checking bench for the space configuration and stall block.
// Assumes: Selects change only while reset is held.
// Notes:   Table rows cover configurations and mode requests; hand tests follow.
`timescale 1ns/10ps
`default_nettype none

module core_space_config_wait_stall_tb;
  logic        CORE_CLK_I = 1'b0, RST_N_I = 1'b0;
  logic        PROGRAM_SPACE_WIDE_SELECT_I = 1'b0, DATA_SPACE_WIDE_SELECT_I = 1'b0;
  logic        FAST_INT_N_I = 1'b1, NORM_INT_N_I = 1'b1, SOFT_TRAP_I = 1'b0;
  logic        DATA_BUS_ENABLE_I = 1'b1, ACCESS_REQ_I = 1'b0, ACCESS_DATA_I = 1'b1;
  logic        ACCESS_WRITE_I = 1'b0, ACCESS_BURST_I = 1'b0;
  logic [31:0] ACCESS_ADDR_I = 32'h0, REG_WDATA_I = 32'h0, rv;
  logic [7:0]  REG_ADDR_I = 8'h0;
  logic        REG_WRITE_I = 1'b0, REG_READ_I = 1'b0, stall_req = 1'b0, busy_req = 1'b0;
  logic [12:0] r;
  wire         CLOCK_STRETCH_N_I, COPROC_ABSENT_I, COPROC_BUSY_I, IRQ_O;
  wire         INTERNAL_PHASE_TWO_CLOCK_O, MEMORY_REQUEST_N_O, BURST_CONTINUATION_O;
  wire         DATA_OUTPUT_ENABLE_N_O, ADDR_EXC_ENABLE_O;
  wire [31:0]  REG_RDATA_O, ADDRESS_O;
  wire [4:0]   MODE_O;
  int          n_fail = 0, tests_run = 0, ph, we, rq;
  // Row fields: program select, data select, request, expected mode, refused.
  logic [12:0] rows [8] = '{
    {2'b00, 5'h10, 5'h03, 1'b1}, {2'b00, 5'h00, 5'h00, 1'b0},
    {2'b00, 5'h02, 5'h02, 1'b0}, {2'b01, 5'h01, 5'h01, 1'b0},
    {2'b01, 5'h13, 5'h03, 1'b1}, {2'b11, 5'h10, 5'h10, 1'b0},
    {2'b11, 5'h12, 5'h12, 1'b0}, {2'b11, 5'h00, 5'h00, 1'b0}};

  // ---------------------------------------------------------------------------
  // Design and memory side
  // ---------------------------------------------------------------------------
  core_space_config_wait_stall uut (
    .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
    .PROGRAM_SPACE_WIDE_SELECT_I(PROGRAM_SPACE_WIDE_SELECT_I),
    .DATA_SPACE_WIDE_SELECT_I(DATA_SPACE_WIDE_SELECT_I), .CLOCK_STRETCH_N_I(CLOCK_STRETCH_N_I),
    .FAST_INT_N_I(FAST_INT_N_I), .NORM_INT_N_I(NORM_INT_N_I), .SOFT_TRAP_I(SOFT_TRAP_I),
    .COPROC_ABSENT_I(COPROC_ABSENT_I), .COPROC_BUSY_I(COPROC_BUSY_I),
    .DATA_BUS_ENABLE_I(DATA_BUS_ENABLE_I), .ACCESS_REQ_I(ACCESS_REQ_I),
    .ACCESS_DATA_I(ACCESS_DATA_I), .ACCESS_WRITE_I(ACCESS_WRITE_I),
    .ACCESS_BURST_I(ACCESS_BURST_I), .ACCESS_ADDR_I(ACCESS_ADDR_I), .REG_ADDR_I(REG_ADDR_I),
    .REG_WDATA_I(REG_WDATA_I), .REG_WRITE_I(REG_WRITE_I), .REG_READ_I(REG_READ_I),
    .REG_RDATA_O(REG_RDATA_O), .IRQ_O(IRQ_O),
    .INTERNAL_PHASE_TWO_CLOCK_O(INTERNAL_PHASE_TWO_CLOCK_O),
    .MEMORY_REQUEST_N_O(MEMORY_REQUEST_N_O), .BURST_CONTINUATION_O(BURST_CONTINUATION_O),
    .ADDRESS_O(ADDRESS_O), .DATA_OUTPUT_ENABLE_N_O(DATA_OUTPUT_ENABLE_N_O),
    .MODE_O(MODE_O), .ADDR_EXC_ENABLE_O(ADDR_EXC_ENABLE_O));

  mem_side_model u_mem (
    .clk_i(CORE_CLK_I), .rst_n_i(RST_N_I), .stall_req_i(stall_req), .busy_req_i(busy_req),
    .clock_stretch_n_o(CLOCK_STRETCH_N_I), .coproc_absent_o(COPROC_ABSENT_I),
    .coproc_busy_o(COPROC_BUSY_I));

  initial begin
    forever #5 CORE_CLK_I = ~CORE_CLK_I;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK_I);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK_I);
    REG_ADDR_I  <= a;
    REG_WDATA_I <= d;
    REG_WRITE_I <= 1'b1;
    @(posedge CORE_CLK_I);
    REG_WRITE_I <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CORE_CLK_I);
    REG_ADDR_I <= a;
    REG_READ_I <= 1'b1;
    @(posedge CORE_CLK_I);
    REG_READ_I <= 1'b0;
    #1 d = REG_RDATA_O;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    chk(d, exp);
  endtask

  task automatic do_reset(input logic p, input logic d);
    @(posedge CORE_CLK_I);
    RST_N_I <= 1'b0;
    PROGRAM_SPACE_WIDE_SELECT_I <= p;
    DATA_SPACE_WIDE_SELECT_I <= d;
    repeat (3) @(posedge CORE_CLK_I);
    RST_N_I <= 1'b1;
    cyc(2);
  endtask

  task automatic watch(input int n);
    ph = 0;
    we = 0;
    rq = 0;
    repeat (n) begin
      @(posedge CORE_CLK_I);
      #1;
      ph += (INTERNAL_PHASE_TWO_CLOCK_O === 1'b1);
      we += (DATA_OUTPUT_ENABLE_N_O === 1'b0);
      rq += (MEMORY_REQUEST_N_O === 1'b0);
    end
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #100000;
    n_fail++;
    print_verdict();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    cyc(2);
    #1;
    chk({22'h0, MODE_O, MEMORY_REQUEST_N_O, DATA_OUTPUT_ENABLE_N_O, ADDR_EXC_ENABLE_O,
         IRQ_O, INTERNAL_PHASE_TWO_CLOCK_O}, 32'h07c);
    for (int i = 0; i < 8; i++) begin
      r = rows[i];
      do_reset(r[12], r[11]);
      wr(8'h00, {27'h0, r[10:6]});
      cyc(6);
      rdchk(8'h04, {21'h0, ~r[11], r[11], r[12], 3'h0, r[5:1]});
      rdchk(8'h08, {31'h0, r[0]});
    end
    wr(8'h0c, 32'h1);
    wr(8'h08, 32'h1);
    do_reset(1'b0, 1'b0);
    wr(8'h00, 32'h10);
    cyc(6);
    chk({31'h0, IRQ_O}, 32'h0);
    wr(8'h0c, 32'h1);
    cyc(2);
    #1 chk({31'h0, IRQ_O}, 32'h1);
    rdchk(8'h0c, 32'h1);
    wr(8'h08, 32'h1);
    cyc(2);
    #1 chk({31'h0, IRQ_O}, 32'h0);
    rdchk(8'h08, 32'h0);
    rdchk(8'h10, 32'h0);
    wr(8'h04, 32'h7ff);
    rdchk(8'h04, 32'h403);
    for (int k = 0; k < 2; k++) begin
      do_reset(k[0], k[0]);
      FAST_INT_N_I <= k[0];
      NORM_INT_N_I <= ~k[0];
      cyc(10);
      rd(8'h04, rv);
      chk(rv & 32'h1f, k ? 32'h12 : 32'h01);
      rdchk(8'h08, 32'h2);
      FAST_INT_N_I <= 1'b1;
      NORM_INT_N_I <= 1'b1;
    end
    for (int k = 0; k < 2; k++) begin
      do_reset(1'b0, k[0]);
      ACCESS_ADDR_I <= 32'h0400_0000;
      ACCESS_REQ_I  <= 1'b1;
      cyc(10);
      ACCESS_REQ_I <= 1'b0;
      rd(8'h08, rv);
      chk(rv & 32'h4, k ? 32'h0 : 32'h4);
      rd(8'h04, rv);
      chk(rv & 32'h1c, 32'h0);
    end
    do_reset(1'b1, 1'b0);
    SOFT_TRAP_I <= 1'b1;
    cyc(1);
    SOFT_TRAP_I <= 1'b0;
    cyc(6);
    rdchk(8'h08, 32'ha);
    rdchk(8'h04, 32'h403);
    do_reset(1'b1, 1'b1);
    ACCESS_ADDR_I  <= 32'h0000_1000;
    ACCESS_WRITE_I <= 1'b1;
    ACCESS_BURST_I <= 1'b1;
    ACCESS_REQ_I   <= 1'b1;
    cyc(4);
    watch(8);
    chk(32'(we), 32'd4);
    chk({30'h0, MEMORY_REQUEST_N_O, BURST_CONTINUATION_O}, 32'h1);
    chk(ADDRESS_O, 32'h0000_1000);
    DATA_BUS_ENABLE_I <= 1'b0;
    cyc(4);
    watch(8);
    chk(32'(we), 32'd0);
    DATA_BUS_ENABLE_I <= 1'b1;
    ACCESS_WRITE_I    <= 1'b0;
    cyc(4);
    watch(8);
    chk(32'(we), 32'd0);
    stall_req <= 1'b1;
    cyc(4);
    ACCESS_ADDR_I <= 32'h0000_2000;
    watch(8);
    chk(32'(ph), 32'd0);
    chk(ADDRESS_O, 32'h0000_1000);
    stall_req <= 1'b0;
    cyc(4);
    watch(8);
    chk(32'(ph), 32'd4);
    chk(ADDRESS_O, 32'h0000_2000);
    busy_req <= 1'b1;
    cyc(6);
    watch(8);
    chk(32'(rq), 32'd0);
    busy_req <= 1'b0;
    cyc(6);
    watch(8);
    chk(32'(rq), 32'd8);
    print_verdict();
  end
endmodule

bind core_space_config_wait_stall core_space_chk u_chk (
  .CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
  .PROGRAM_SPACE_WIDE_SELECT_I(PROGRAM_SPACE_WIDE_SELECT_I),
  .DATA_SPACE_WIDE_SELECT_I(DATA_SPACE_WIDE_SELECT_I), .CLOCK_STRETCH_N_I(CLOCK_STRETCH_N_I),
  .FAST_INT_N_I(FAST_INT_N_I), .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
  .REG_WRITE_I(REG_WRITE_I), .INTERNAL_PHASE_TWO_CLOCK_O(INTERNAL_PHASE_TWO_CLOCK_O),
  .MEMORY_REQUEST_N_O(MEMORY_REQUEST_N_O), .BURST_CONTINUATION_O(BURST_CONTINUATION_O),
  .ADDRESS_O(ADDRESS_O), .DATA_OUTPUT_ENABLE_N_O(DATA_OUTPUT_ENABLE_N_O),
  .MODE_O(MODE_O), .ADDR_EXC_ENABLE_O(ADDR_EXC_ENABLE_O));

`default_nettype wire
